// ### swc_pkg.sv
/*
  Package for the SYSREF capture window block: register byte addresses,
  field layouts, reset values and counts shared by the design files.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
// How it works
// - SYSREF is captured on a fixed device clock edge, same every reset.
// - Single-channel mode samples SYSREF on both clock edges, doubling the window.
// - Position detector finds SYSREF in the clock cycle; result kept as map.
// - Map has 24 positions; low, mid, high bytes at 0x02c, 0x02d, 0x02e.
// - Map counts as valid only after three SYSREF rising edges.
// - A map bit is 1 for a risky position and 0 for a safe one.
// - Map bits 0 and 23 always read 1.
// - Each sampling instant is a delayed clock; the chosen one samples SYSREF.
// - Position select holds the index of the chosen map bit.
// - Position select reaches only positions 0 to 15.
// - Fine step select 0 gives coarse steps, 1 gives fine steps.
package swc_pkg;
  // Byte addresses: printed offsets count words, not bytes, so index * 4
  localparam logic [11:0] SWC_IDX_MAP_LOW  = 12'h02c;
  localparam logic [11:0] SWC_IDX_MAP_MID  = 12'h02d;
  localparam logic [11:0] SWC_IDX_MAP_HIGH = 12'h02e;
  localparam logic [11:0] SWC_IDX_CTRL     = 12'h030;
  localparam logic [11:0] SWC_IDX_STATUS   = 12'h031;
  localparam logic [11:0] SWC_ADDR_MAP_LOW  = 12'(SWC_IDX_MAP_LOW  * 4);
  localparam logic [11:0] SWC_ADDR_MAP_MID  = 12'(SWC_IDX_MAP_MID  * 4);
  localparam logic [11:0] SWC_ADDR_MAP_HIGH = 12'(SWC_IDX_MAP_HIGH * 4);
  localparam logic [11:0] SWC_ADDR_CTRL     = 12'(SWC_IDX_CTRL     * 4);
  localparam logic [11:0] SWC_ADDR_STATUS   = 12'(SWC_IDX_STATUS   * 4);
  // Control register fields
  localparam int SWC_CTRL_SEL_LSB  = 0;
  localparam int SWC_CTRL_FINE_BIT = 4;
  localparam int SWC_CTRL_DES_BIT  = 5;
  // Status register fields
  localparam int SWC_STAT_VALID_BIT = 0;
  localparam int SWC_STAT_EDGE_LSB  = 1;
  // Counts and reset values
  localparam int          SWC_POSITIONS      = 24;
  localparam int          SWC_SEL_POSITIONS  = 16;
  localparam logic [1:0]  SWC_EDGES_FOR_VALID = 2'h3;
  localparam logic [3:0]  SWC_SEL_RESET       = 4'h0;
  localparam logic        SWC_FINE_RESET      = 1'b1;
  localparam logic        SWC_DES_RESET       = 1'b0;
  localparam logic [23:0] SWC_MAP_RESET       = 24'hffffff;
  localparam logic [23:0] SWC_EDGE_FORCE      = 24'h800001;
endpackage

// ### swc_sync.sv
/*
  Two-flip-flop synchroniser for a bus of levels.
  Assumes inputs arrive from outside the ref_clk_i domain.
*/
`timescale 1ns/1ps
module swc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_i, // Block clock
  input  wire logic             rst_i,     // Synchronous reset
  input  wire logic [WIDTH-1:0] async_i,   // Asynchronous levels
  output logic      [WIDTH-1:0] sync_o     // Synchronised levels
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // Next values of both stages
  always_comb begin
    next_meta = rst_i ? '0 : async_i;
    next_sync = rst_i ? '0 : meta;
  end

  // Register the stages
  always_ff @(posedge ref_clk_i) begin
    meta   <= next_meta;
    sync_o <= next_sync;
  end
endmodule

// ### swc_apb_slave.sv
/*
  APB register slave for the SYSREF capture window block.
  Holds the control register, returns the map and status.
  Assumes APB3 signalling with zero wait states and 32-bit data.
*/
`timescale 1ns/1ps
module swc_apb_slave
  import swc_pkg::*;
(
  input  wire logic        ref_clk_i,  // Block clock
  input  wire logic        rst_i,      // Synchronous reset
  input  wire logic        psel_i,     // APB select
  input  wire logic        penable_i,  // APB enable
  input  wire logic        pwrite_i,   // APB direction
  input  wire logic [11:0] paddr_i,    // APB byte address
  input  wire logic [31:0] pwdata_i,   // APB write data
  output logic      [31:0] prdata_o,   // APB read data
  output logic             pready_o,   // APB ready
  output logic             pslverr_o,  // APB error
  input  wire logic [23:0] map_i,      // Window map
  input  wire logic        valid_i,    // Map valid
  input  wire logic [1:0]  edges_i,    // Edges seen, saturating
  output logic      [3:0]  sel_o,      // Position select
  output logic             fine_o,     // Fine step select
  output logic             des_o       // Dual-edge mode
);
  logic [3:0] next_sel;
  logic       next_fine;
  logic       next_des;

  // Address recognised by the map
  function automatic logic swc_hit(input logic [11:0] a);
    return a == SWC_ADDR_MAP_LOW || a == SWC_ADDR_MAP_MID || a == SWC_ADDR_MAP_HIGH
        || a == SWC_ADDR_CTRL || a == SWC_ADDR_STATUS;
  endfunction

  // Combinational answer, no wait states
  always_comb begin
    pready_o  = 1'b1;
    pslverr_o = psel_i && penable_i && !swc_hit(paddr_i);
    prdata_o  = 32'h0;
    case (paddr_i)
      SWC_ADDR_MAP_LOW:  prdata_o = {24'h0, map_i[7:0]};
      SWC_ADDR_MAP_MID:  prdata_o = {24'h0, map_i[15:8]};
      SWC_ADDR_MAP_HIGH: prdata_o = {24'h0, map_i[23:16]};
      SWC_ADDR_CTRL: begin
        prdata_o[SWC_CTRL_SEL_LSB +: 4] = sel_o;
        prdata_o[SWC_CTRL_FINE_BIT]     = fine_o;
        prdata_o[SWC_CTRL_DES_BIT]      = des_o;
      end
      SWC_ADDR_STATUS: begin
        prdata_o[SWC_STAT_VALID_BIT]     = valid_i;
        prdata_o[SWC_STAT_EDGE_LSB +: 2] = edges_i;
      end
      default: prdata_o = 32'h0;
    endcase
  end

  // Control register writes; map registers are read-only
  always_comb begin
    next_sel  = sel_o;
    next_fine = fine_o;
    next_des  = des_o;
    if (rst_i) begin
      next_sel  = SWC_SEL_RESET;
      next_fine = SWC_FINE_RESET;
      next_des  = SWC_DES_RESET;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == SWC_ADDR_CTRL) begin
      next_sel  = pwdata_i[SWC_CTRL_SEL_LSB +: 4];
      next_fine = pwdata_i[SWC_CTRL_FINE_BIT];
      next_des  = pwdata_i[SWC_CTRL_DES_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    sel_o  <= next_sel;
    fine_o <= next_fine;
    des_o  <= next_des;
  end
endmodule

// ### swc_top.sv
/*
  SYSREF capture window block. Samples SYSREF at delayed clock positions,
  builds the 24-bit window map, and captures SYSREF at the selected one.
  Assumes the analogue delay line outside delivers, for each position p,
  the SYSREF level sampled at that delay on the rising edge (tap_rise_i)
  and on the falling edge (tap_fall_i); step size follows step_fine_o.
*/
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module swc_top
  import swc_pkg::*;
#(
  parameter int POSITIONS = SWC_POSITIONS
) (
  input  wire logic                 ref_clk_i,   // Device clock, 125 MHz
  input  wire logic                 rst_i,       // Synchronous reset
  input  wire logic                 psel_i,      // APB select
  input  wire logic                 penable_i,   // APB enable
  input  wire logic                 pwrite_i,    // APB direction
  input  wire logic [11:0]          paddr_i,     // APB byte address
  input  wire logic [31:0]          pwdata_i,    // APB write data
  output logic      [31:0]          prdata_o,    // APB read data
  output logic                      pready_o,    // APB ready
  output logic                      pslverr_o,   // APB error
  input  wire logic [POSITIONS-1:0] tap_rise_i,  // SYSREF at each delay, rising
  input  wire logic [POSITIONS-1:0] tap_fall_i,  // SYSREF at each delay, falling
  output logic                      step_fine_o, // Delay line step size select
  output logic                      sysref_o,    // Captured SYSREF level
  output logic                      sysref_edge_o, // Captured rising edge pulse
  output logic                      map_valid_o  // Window map valid
);
  // Elaboration check: the map layout is fixed at 24 positions
  if (POSITIONS != SWC_POSITIONS) begin : g_bad
    $error("swc_top supports exactly 24 positions");
  end

  logic [POSITIONS-1:0] rise_s;
  logic [POSITIONS-1:0] fall_s;
  logic [POSITIONS-1:0] rise_d;
  logic [POSITIONS-1:0] next_rise_d;
  logic [POSITIONS-1:0] risk;
  logic [POSITIONS-1:0] next_risk;
  logic [POSITIONS-1:0] map;
  logic [1:0]           edges;
  logic [1:0]           next_edges;
  logic                 cap;
  logic                 next_cap;
  logic                 edge_q;
  logic                 next_edge;
  logic [3:0]           sel;
  logic                 fine;
  logic                 des;
  logic                 ref_rise;
  logic                 tap_sel;

  // Taps come from the analogue side, so synchronise them
  swc_sync #(.WIDTH(POSITIONS)) u_sync_rise (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (tap_rise_i),
    .sync_o    (rise_s)
  );
  swc_sync #(.WIDTH(POSITIONS)) u_sync_fall (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (tap_fall_i),
    .sync_o    (fall_s)
  );

  swc_apb_slave u_regs (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .map_i     (map),
    .valid_i   (map_valid_o),
    .edges_i   (edges),
    .sel_o     (sel),
    .fine_o    (fine),
    .des_o     (des)
  );

  assign step_fine_o = fine;

  // Reference edge: middle tap on the rising edge marks a SYSREF rise
  assign ref_rise = rise_s[POSITIONS/2] && !rise_d[POSITIONS/2];

  // Selected tap; dual-edge mode also takes the falling sample
  assign tap_sel = rise_s[sel] || (des && fall_s[sel]);

  // Risk: a tap whose sample differs from a neighbour at a SYSREF rise
  // sits on a transition, so it may violate setup or hold
  always_comb begin
    next_risk = risk;
    if (rst_i) begin
      next_risk = '0;
    end else if (ref_rise) begin
      for (int p = 0; p < POSITIONS; p++) begin
        next_risk[p] = (p > 0 && rise_s[p] != rise_s[p-1])
                    || (p < POSITIONS-1 && rise_s[p] != rise_s[p+1]);
      end
    end
  end

  // Map with edge positions forced to 1
  always_comb begin
    map = risk | SWC_EDGE_FORCE;
    if (!map_valid_o) begin
      map = SWC_MAP_RESET;
    end
  end

  // Edge counter, saturating at three
  always_comb begin
    next_edges = edges;
    if (rst_i) begin
      next_edges = 2'h0;
    end else if (ref_rise && edges != SWC_EDGES_FOR_VALID) begin
      next_edges = edges + 2'h1;
    end
  end

  // Capture at the chosen position, used for every later edge
  always_comb begin
    next_rise_d  = rst_i ? '0 : rise_s;
    next_cap     = rst_i ? 1'b0 : tap_sel;
    next_edge    = rst_i ? 1'b0 : (tap_sel && !cap);
  end

  always_ff @(posedge ref_clk_i) begin
    rise_d  <= next_rise_d;
    risk    <= next_risk;
    edges   <= next_edges;
    cap     <= next_cap;
    edge_q  <= next_edge;
  end

  assign map_valid_o   = (edges == SWC_EDGES_FOR_VALID);
  assign sysref_o      = cap;
  assign sysref_edge_o = edge_q;
endmodule

// ### swc_sva.sv
/*
  Checker for swc_top: APB answers, map reads and capture pulses.
  Assumes it is bound into swc_top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module swc_sva
  import swc_pkg::*;
#(
  parameter int POSITIONS = SWC_POSITIONS
) (
  input wire logic                 ref_clk_i, rst_i,            // Clock, reset
  input wire logic                 psel_i, penable_i, pwrite_i, // APB control
  input wire logic [11:0]          paddr_i,                     // APB address
  input wire logic [31:0]          pwdata_i, prdata_o,          // APB data
  input wire logic                 pready_o, pslverr_o,         // APB answer
  input wire logic [POSITIONS-1:0] tap_rise_i, tap_fall_i,      // Delay taps
  input wire logic                 step_fine_o, sysref_o,       // Step, capture
  input wire logic                 sysref_edge_o, map_valid_o   // Edge, valid
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  // Decode of the five register words
  assign mapped = paddr_i inside {SWC_ADDR_MAP_LOW, SWC_ADDR_MAP_MID,
                                  SWC_ADDR_MAP_HIGH, SWC_ADDR_CTRL, SWC_ADDR_STATUS};
  // Access phases of interest
  sequence rd_acc(a);
    psel_i && penable_i && !pwrite_i && paddr_i == a;
  endsequence
  sequence wr_ctrl;
    psel_i && penable_i && pwrite_i && paddr_i == SWC_ADDR_CTRL;
  endsequence
  chk_ready_high: assert property (pready_o) else $error("ready dropped");
  chk_err_unmapped: assert property (psel_i && penable_i && !mapped |-> pslverr_o)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (psel_i && penable_i && mapped |-> !pslverr_o)
    else $error("error on mapped access");
  chk_map_low_end: assert property (rd_acc(SWC_ADDR_MAP_LOW) |-> prdata_o[0])
    else $error("map bit 0 clear");
  chk_map_high_end: assert property (rd_acc(SWC_ADDR_MAP_HIGH) |-> prdata_o[7])
    else $error("map bit 23 clear");
  chk_map_invalid: assert property (rd_acc(SWC_ADDR_MAP_LOW) |->
    prdata_o[31:8] == 24'h0 && (map_valid_o || prdata_o[7:0] == 8'hff))
    else $error("map read wrong before valid");
  chk_fine_follow: assert property (wr_ctrl |=>
    step_fine_o == $past(pwdata_i[SWC_CTRL_FINE_BIT])) else $error("step size not applied");
  chk_valid_hold: assert property (map_valid_o |=> map_valid_o)
    else $error("valid dropped");
  chk_edge_pulse: assert property ($rose(sysref_o) |-> sysref_edge_o ##1 !sysref_edge_o)
    else $error("edge pulse wrong");
  chk_edge_cause: assert property (sysref_edge_o |->
    sysref_o && !$past(sysref_o)) else $error("edge pulse without rise");
endmodule
bind swc_top swc_sva #(.POSITIONS(POSITIONS)) swc_sva_inst (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tap_rise_i(tap_rise_i),
  .tap_fall_i(tap_fall_i), .step_fine_o(step_fine_o), .sysref_o(sysref_o),
  .sysref_edge_o(sysref_edge_o), .map_valid_o(map_valid_o));

// ### swc_sysref_model.sv
/*
  Clock generator side: SYSREF as seen at each delay tap.
  Assumes taps ordered by delay; fire_i starts one SYSREF pulse.
*/
`timescale 1ns/1ps
module swc_sysref_model (
  input  wire logic        ref_clk_i,  // Device clock
  input  wire logic        fire_i,     // Start one pulse
  input  wire logic [4:0]  step_i,     // First tap that sees the rise
  output logic      [23:0] tap_rise_o, // Tap samples, rising edge
  output logic      [23:0] tap_fall_o  // Tap samples, falling edge
);
  logic [1:0] cnt = 2'h0;
  // Rise lands between taps, then three cycles high, then low
  always @(posedge ref_clk_i) begin
    if (fire_i) begin
      tap_rise_o <= ~((24'h1 << step_i) - 24'h1);
      cnt <= 2'h3;
    end else if (cnt != 2'h0) begin
      tap_rise_o <= 24'hffffff;
      cnt <= cnt - 2'h1;
    end else begin
      tap_rise_o <= 24'h0;
    end
  end
  // Falling edge half a cycle on: one tap earlier
  assign tap_fall_o = tap_rise_o | (tap_rise_o >> 1);
endmodule

// ### tb.sv
/*
  Self-checking bench for swc_top: APB master, SYSREF model, checks.
  Assumes zero-wait APB slave and the capture latency in the notes.
*/
`timescale 1ns/1ps
module tb;
  import swc_pkg::*;
  logic        ref_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h39b2;
  logic        pready, pslverr, step_fine, sysref, sysref_edge, map_valid, err, ed;
  logic [4:0]  step = 5'h3;
  logic [23:0] tap_r, tap_f, m;
  int          fail_count = 0, checks = 0, n, i, s, kk;
  swc_top swc_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tap_rise_i(tap_r),
    .tap_fall_i(tap_f), .step_fine_o(step_fine), .sysref_o(sysref),
    .sysref_edge_o(sysref_edge), .map_valid_o(map_valid));
  swc_sysref_model swc_sysref_model_inst (.ref_clk_i(ref_clk_i), .fire_i(fire),
    .step_i(step), .tap_rise_o(tap_r), .tap_fall_o(tap_f));
  // 125 MHz clock
  initial forever #4 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // One SYSREF pulse; n is edges until the capture goes high
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    fire <= 1'b1;
    step <= 5'(k);
    @(posedge ref_clk_i);
    fire <= 1'b0;
    ed = 1'b0;
    for (n = 1; n < 9; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (sysref === 1'b1) begin
        ed = sysref_edge;
        break;
      end
    end
    repeat (12) @(posedge ref_clk_i);
  endtask
  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdchk(SWC_ADDR_CTRL, 32'(SWC_FINE_RESET) << SWC_CTRL_FINE_BIT);
    chk(32'(step_fine), 32'h1);
    for (i = 0; i < 3; i++) rdchk(12'(SWC_ADDR_MAP_LOW + 4 * i), 32'hff);
    apb(1'b1, SWC_ADDR_MAP_LOW, 32'h0);
    rdchk(SWC_ADDR_MAP_LOW, 32'hff);
    rdchk(12'h0bc, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, SWC_ADDR_CTRL, 32'h20);
    rdchk(SWC_ADDR_CTRL, 32'h20);
    chk(32'(step_fine), 32'h0);
    apb(1'b1, SWC_ADDR_CTRL, 32'h10);
    // Valid only from the third rise; edge count saturates
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      s = 3 + int'(lfsr % 10);
      pulse(s);
      chk(32'(map_valid), 32'(i >= 2));
      rdchk(SWC_ADDR_STATUS, 32'((i > 1 ? 3 : i + 1) * 2 + (i >= 2 ? 1 : 0)));
    end
    apb(1'b0, SWC_ADDR_MAP_LOW, 32'h0);
    m[7:0] = rd[7:0];
    apb(1'b0, SWC_ADDR_MAP_MID, 32'h0);
    m[15:8] = rd[7:0];
    apb(1'b0, SWC_ADDR_MAP_HIGH, 32'h0);
    m[23:16] = rd[7:0];
    chk(32'(m), 32'((24'h3 << (s - 1)) | 24'h800001));
    // Midway between the edge region at bit 0 and the transition
    apb(1'b1, SWC_ADDR_CTRL, 32'h10 | 32'((s - 1) / 2));
    pulse(s);
    chk(32'(n), 32'h4);
    // Selected position sets capture delay
    for (i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      s = (i == 0) ? 15 : int'(lfsr % 16);
      kk = 3 + int'((lfsr >> 8) % 10);
      apb(1'b1, SWC_ADDR_CTRL, 32'h10 | 32'(s));
      pulse(kk);
      chk(32'(n), 32'(s < kk ? 4 : 3));
      chk(32'(ed), 32'h1);
    end
    // Dual-edge: falling sample sees the rise one position earlier
    apb(1'b1, SWC_ADDR_CTRL, 32'h30 | 32'(kk - 1));
    pulse(kk);
    chk(32'(n), 32'h3);
    apb(1'b1, SWC_ADDR_CTRL, 32'h10);
    rdchk(SWC_ADDR_CTRL, 32'h10);
    end_sim();
  end
endmodule
